/* File: logic/tsi_i2c_slave.v */
// i2c target port with auto-incrementing register pointer and nack gating
`timescale 1ns/1ps
`default_nettype none
`include "tsi_defs.vh"
module tsi_i2c_slave #(
	parameter BOOT_CYC  = (`TSI_BOOT_WAIT_US * (`TSI_CLK_KHZ / 1000)),
	parameter GAP_CYC   = (`TSI_GAP_LIMIT_MS * `TSI_CLK_KHZ),
	parameter SAVE_CYC  = (`TSI_SAVE_TIME_MS * `TSI_CLK_KHZ),
	parameter WAKE_CYC  = 64
) (
	// clock and reset
	input  wire       clock,
	input  wire       sys_rst,
	// i2c pins, oe low means drive low
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output wire       sda_oe_n,
	// configured slave address
	input  wire [6:0] slave_addr,
	// power state handshake with the core
	input  wire       low_power,
	output reg        wake_req,
	output reg        bus_busy,
	// register file port
	output reg  [7:0] reg_addr,
	output reg  [7:0] reg_wdata,
	output reg        reg_we,
	input  wire [7:0] reg_rdata,
	output reg        save_busy
);
	// *****
	// scl and sda inputs synchronised before use
	// *****
	wire [1:0] pins_s;
	tsi_sync #(.W(2)) u_sync (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.async_in ({scl_in, sda_in}),
		.sync_out (pins_s)
	);
	wire scl_s = pins_s[1];
	wire sda_s = pins_s[0];
	reg  scl_d_r;                  // previous scl
	reg  sda_d_r;                  // previous sda
	wire scl_rise = scl_s & ~scl_d_r;
	wire scl_fall = ~scl_s & scl_d_r;
	wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
	wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;

	// states, one-hot
	localparam ST_IDLE = 6'h01;
	localparam ST_ADDR = 6'h02;
	localparam ST_AACK = 6'h04;
	localparam ST_WR   = 6'h08;
	localparam ST_RD   = 6'h10;
	localparam ST_DACK = 6'h20;

	reg [5:0]  st_r;               // protocol state
	reg [3:0]  bit_r;              // bits seen in byte
	reg [7:0]  sh_r;               // shift register
	reg        rnw_r;              // read direction
	reg        have_ptr_r;         // pointer byte received
	reg        drive_r;            // pull sda low
	reg        ack_r;              // ack decided for this slot
	reg        mack_r;             // host acked read byte
	reg [31:0] boot_r;             // boot wait counter
	reg [31:0] gap_r;              // byte gap counter
	reg [31:0] save_r;             // save command counter
	reg [7:0]  wake_r;             // wake-up counter
	reg        nack_first_r;       // nack first active transaction
	reg        ptr_inc_r;          // delayed pointer advance on write
	reg        rd_next_r;          // launch next read byte

	assign sda_out  = 1'b0;
	assign sda_oe_n = ~drive_r;

	wire addr_ok = (slave_addr >= `TSI_ADDR_MIN) && (slave_addr <= `TSI_ADDR_MAX);
	wire [6:0] my_addr = addr_ok ? slave_addr : `TSI_ADDR_DEFAULT;
	wire booting = (boot_r != 32'h0);

	// *****
	// main protocol engine, no stretching ever
	// *****
	always @(posedge clock) begin
		if (sys_rst) begin
			scl_d_r      <= 1'b1;
			sda_d_r      <= 1'b1;
			st_r         <= ST_IDLE;
			bit_r        <= 4'h0;
			sh_r         <= 8'h00;
			rnw_r        <= 1'b0;
			have_ptr_r   <= 1'b0;
			drive_r      <= 1'b0;
			ack_r        <= 1'b0;
			mack_r       <= 1'b0;
			reg_addr     <= 8'h00;
			reg_wdata    <= 8'h00;
			reg_we       <= 1'b0;
			save_busy    <= 1'b0;
			wake_req     <= 1'b0;
			bus_busy     <= 1'b0;
			boot_r       <= BOOT_CYC;
			gap_r        <= 32'h0;
			save_r       <= 32'h0;
			wake_r       <= 8'h00;
			nack_first_r <= 1'b0;
			ptr_inc_r    <= 1'b0;
			rd_next_r    <= 1'b0;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			reg_we  <= 1'b0;
			if (booting)
				boot_r <= boot_r - 32'h1;
			if (save_r != 32'h0)
				save_r <= save_r - 32'h1;
			else
				save_busy <= 1'b0;
			// wake delay then one more nack
			if (wake_r != 8'h0)
				wake_r <= wake_r - 8'h1;
			else
				wake_req <= 1'b0;
			// busy while transfer or scl low
			bus_busy <= (st_r != ST_IDLE) | ~scl_s;
			if (st_r == ST_IDLE || scl_fall)
				gap_r <= 32'h0;
			else if (gap_r >= GAP_CYC[31:0]) begin
				st_r    <= ST_IDLE;
				drive_r <= 1'b0;
			end else
				gap_r <= gap_r + 32'h1;
			if (start_c) begin
				st_r    <= ST_ADDR;
				bit_r   <= 4'h0;
				drive_r <= 1'b0;
			end else if (stop_c) begin
				st_r    <= ST_IDLE;
				drive_r <= 1'b0;
			end else begin
				case (st_r)
				ST_ADDR, ST_WR: begin
					if (scl_rise) begin
						sh_r  <= {sh_r[6:0], sda_s};
						bit_r <= bit_r + 4'h1;
					end
					if (scl_fall && bit_r == 4'h8) begin
						bit_r <= 4'h0;
						if (st_r == ST_ADDR) begin
							if (sh_r[7:1] != my_addr)
								st_r <= ST_IDLE;
							else begin
								rnw_r <= sh_r[0];
								st_r  <= ST_AACK;
								if (booting || save_busy || low_power || wake_req || nack_first_r) begin
									ack_r <= 1'b0;
									if (low_power && !wake_req) begin
										wake_req     <= 1'b1;
										wake_r       <= WAKE_CYC[7:0];
										nack_first_r <= 1'b1;
									end else if (!low_power && !wake_req)
										nack_first_r <= 1'b0;
								end else begin
									ack_r   <= 1'b1;
									drive_r <= 1'b1;
								end
							end
						end else begin
							st_r    <= ST_DACK;
							ack_r   <= 1'b1;
							drive_r <= 1'b1;
							if (!have_ptr_r) begin
								reg_addr   <= sh_r;
								have_ptr_r <= 1'b1;
							end else begin
								if (reg_addr < `TSI_RO_BASE || reg_addr == `TSI_SAVE_CMD_REG) begin
									reg_we    <= 1'b1;
									reg_wdata <= sh_r;
								end
								if (reg_addr == `TSI_SAVE_CMD_REG && sh_r == `TSI_SAVE_CMD_VAL) begin
									save_busy <= 1'b1;
									// load one short so busy lasts exactly SAVE_CYC cycles
									save_r    <= SAVE_CYC[31:0] - 32'h1;
								end
							end
						end
					end
				end
				ST_AACK: begin
					if (scl_fall) begin
						drive_r <= 1'b0;
						if (!ack_r)
							st_r <= ST_IDLE;
						else if (rnw_r) begin
							sh_r    <= reg_rdata;
							drive_r <= ~reg_rdata[7];
							bit_r   <= 4'h1;
							st_r    <= ST_RD;
						end else begin
							have_ptr_r <= 1'b0;
							st_r       <= ST_WR;
						end
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						if (bit_r == 4'h8) begin
							drive_r <= 1'b0;
							st_r    <= ST_DACK;
							bit_r   <= 4'h0;
						end else begin
							drive_r <= ~sh_r[6];
							sh_r    <= {sh_r[6:0], 1'b0};
							bit_r   <= bit_r + 4'h1;
						end
					end
				end
				ST_DACK: begin
					if (rnw_r && scl_rise)
						mack_r <= ~sda_s;
					if (scl_fall) begin
						drive_r <= 1'b0;
						if (!rnw_r)
							st_r <= ST_WR;
						else
							st_r <= ST_IDLE;    // read reload follows via rd_next_r only if the host acked
					end
				end
				default: st_r <= ST_IDLE;
				endcase
			end
			if (st_r == ST_WR && scl_fall && bit_r == 4'h8 && have_ptr_r)
				ptr_inc_r <= 1'b1;
			else
				ptr_inc_r <= 1'b0;
			if (ptr_inc_r)
				reg_addr <= reg_addr + 8'h01;
			if (st_r == ST_DACK && rnw_r && scl_fall)
				reg_addr <= reg_addr + 8'h01;
			if (st_r == ST_DACK && rnw_r && scl_fall && mack_r)
				rd_next_r <= 1'b1;
			else
				rd_next_r <= 1'b0;
			// load next read byte once rdata settles
			if (rd_next_r) begin
				sh_r    <= reg_rdata;
				drive_r <= ~reg_rdata[7];
				bit_r   <= 4'h1;
				st_r    <= ST_RD;
			end
		end
	end
endmodule // tsi_i2c_slave
`default_nettype wire

/* File: logic/tsi_defs.vh */
// constants shared by the touch-sense i2c register access port
`ifndef TSI_DEFS_VH
`define TSI_DEFS_VH
`define TSI_CLK_KHZ          250000
`define TSI_BOOT_WAIT_US     15000
`define TSI_GAP_LIMIT_MS     340
`define TSI_SAVE_TIME_MS     220
`define TSI_ADDR_DEFAULT     7'h37
`define TSI_ADDR_MIN         7'h08
`define TSI_ADDR_MAX         7'h77
`define TSI_SAVE_CMD_REG     8'h86
`define TSI_SAVE_CMD_VAL     8'h02
`define TSI_RO_BASE          8'h80
`endif

/* File: logic/tsi_sync.v */
// two flip-flop synchroniser for scl and sda, input glitches are not filtered
`timescale 1ns/1ps
`default_nettype none
module tsi_sync #(
	parameter W = 2
) (
	// clock and reset
	input  wire         clock,
	input  wire         sys_rst,
	// raw and synchronised levels
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);
	// first stage, read only by the second
	reg [W-1:0] meta_r;
	// *****
	// two stages, reset to idle-high bus
	// *****
	always @(posedge clock) begin
		if (sys_rst) begin
			meta_r   <= {W{1'b1}};
			sync_out <= {W{1'b1}};
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule // tsi_sync
`default_nettype wire

/* File: verif/tsi_host.sv */
// i2c host master model for the target port
`timescale 1ns/1ps
`default_nettype none
module tsi_host (
	// clock and bus level
	input  wire logic clock,
	input  wire logic sda_line,
	// open-drain drives, high means released
	output var  logic scl,
	output var  logic sda_drv
);
	// bus idle: both lines released
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// half bit, well above the five-clock minimum
	task automatic hw;
		repeat (8) @(negedge clock);
	endtask
	// start, also used as repeated start
	task automatic start;
		sda_drv = 1'b1;
		hw;
		scl = 1'b1;
		hw;
		sda_drv = 1'b0;
		hw;
		scl = 1'b0;
	endtask
	task automatic stop;
		sda_drv = 1'b0;
		hw;
		scl = 1'b1;
		hw;
		sda_drv = 1'b1;
		hw;
	endtask
	// nine bits; sampled late in scl high so the target has settled
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sda_drv = tx[i];
			hw;
			scl = 1'b1;
			hw;
			rx[i] = sda_line;
			scl = 1'b0;
		end
	endtask
endmodule // tsi_host
`default_nettype wire

/* File: verif/tsi_i2c_slave_properties.sv */
// assertions on the ports of the i2c target port
`timescale 1ns/1ps
`default_nettype none
module tsi_i2c_slave_properties #(
	parameter BOOT_CYC = 100,
	parameter SAVE_CYC = 500,
	parameter WAKE_CYC = 64
) (
	// clock, reset and watched ports of the target
	input wire logic       clock,
	input wire logic       sys_rst,
	input wire logic       scl_in,
	input wire logic       sda_out,
	input wire logic       sda_oe_n,
	input wire logic       low_power,
	input wire logic       wake_req,
	input wire logic       bus_busy,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_we,
	input wire logic       save_busy
);
	int boot_cnt;
	int save_cnt;
	// cycles since reset release, saturating
	always @(posedge clock) begin
		if (sys_rst) boot_cnt <= 0;
		else if (boot_cnt < BOOT_CYC) boot_cnt <= boot_cnt + 1;
	end
	// length of the current save run
	always @(posedge clock) save_cnt <= (sys_rst || !save_busy) ? 0 : save_cnt + 1;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_save_cmd;
		reg_we && reg_addr == 8'h86 && reg_wdata == 8'h02;
	endsequence
	sequence s_wake_hold;
		wake_req [*7];
	endsequence
	property p_boot; boot_cnt < BOOT_CYC |-> sda_oe_n; endproperty
	property p_wake; $rose(wake_req) |-> $past(low_power) ##1 s_wake_hold; endproperty
	property p_wnack; wake_req |-> sda_oe_n; endproperty
	property p_save; s_save_cmd |=> save_busy; endproperty
	property p_slen; save_cnt <= SAVE_CYC; endproperty
	property p_ro; reg_we |-> reg_addr < 8'h80 || reg_addr == 8'h86; endproperty
	property p_pulse; reg_we |=> !reg_we; endproperty
	property p_inc; reg_we |=> reg_addr == $past(reg_addr) + 8'h01; endproperty
	property p_hold; scl_in && $past(scl_in) |-> $stable(sda_oe_n) && sda_out == 1'b0; endproperty
	property p_busy; !scl_in [*4] |-> bus_busy; endproperty
	a_boot: assert property (p_boot) else $error("ack in boot wait");
	a_wake: assert property (p_wake) else $error("bad wake request");
	a_wnack: assert property (p_wnack) else $error("ack while waking");
	a_save: assert property (p_save) else $error("save not started");
	a_slen: assert property (p_slen) else $error("save too long");
	a_ro: assert property (p_ro) else $error("read-only written");
	a_pulse: assert property (p_pulse) else $error("write strobe long");
	a_inc: assert property (p_inc) else $error("pointer not advanced");
	a_hold: assert property (p_hold) else $error("sda moved in scl high");
	a_busy: assert property (p_busy) else $error("busy not shown");
endmodule // tsi_i2c_slave_properties
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the i2c target port
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int BOOT = 400;
	localparam int GAP  = 2000;
	logic       clock = 1'b0;
	logic       sys_rst = 1'b1;
	logic       low_power = 1'b0;
	logic [6:0] slave_addr = 7'h37;
	logic [7:0] mem [256];
	int         n_fail = 0;
	int         checked = 0;
	wire        sda_oe_n, sda_out, scl, sda_drv, wake_req, bus_busy, reg_we, save_busy;
	wire  [7:0] reg_addr, reg_wdata;
	// open-drain line with pull-up; target shows sda_out while enabled
	wire        sda_line = sda_drv & (sda_oe_n | sda_out);
	always #2 clock = ~clock;
	// register file behind the port
	always @(posedge clock) if (reg_we) mem[reg_addr] <= reg_wdata;
	tsi_host h (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
	tsi_i2c_slave #(.BOOT_CYC(BOOT), .GAP_CYC(GAP), .SAVE_CYC(500), .WAKE_CYC(64)) dut (.clock(clock),
		.sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.slave_addr(slave_addr),
		.low_power(low_power), .wake_req(wake_req), .bus_busy(bus_busy), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(mem[reg_addr]), .save_busy(save_busy));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] d, output logic ack);
		logic [8:0] rx;
		h.xfer({d, 1'b1}, rx);
		ack = ~rx[0];
	endtask
	task automatic open(input logic [7:0] ab);
		logic ack;
		ack = 1'b0;
		for (int i = 0; i < 9 && !ack; i++) begin
			h.start;
			wr(ab, ack);
		end
		check(ack, 8'h01);
	endtask
	task automatic t_boot;
		logic a;
		h.start;
		wr(8'h6E, a);
		check(a, 8'h00);
		h.stop;
		repeat (BOOT) @(negedge clock);
		check(bus_busy, 8'h00);
		$display("boot test done");
	endtask
	task automatic t_write;
		logic a0, a1, a2;
		open(8'h6E);
		wr(8'h10, a0);
		wr(8'h5A, a1);
		wr(8'hA5, a2);
		h.stop;
		check({a0, a1, a2}, 8'h07);
		check(mem[8'h10], 8'h5A);
		check(mem[8'h11], 8'hA5);
		$display("write test done");
	endtask
	task automatic t_gap;
		logic a;
		open(8'h6E);
		wr(8'h20, a);
		check(bus_busy, 8'h01);
		// scl held low past the gap limit
		repeat (GAP + 100) @(negedge clock);
		wr(8'h77, a);
		h.stop;
		check(a, 8'h00);
		check(mem[8'h20], 8'h20);
		$display("gap test done");
	endtask
	task automatic t_read;
		logic a;
		logic [8:0] rx;
		slave_addr = 7'h05;
		open(8'h6E);
		wr(8'h10, a);
		h.stop;
		open(8'h6F);
		h.xfer({8'hFF, 1'b0}, rx);
		check(rx[8:1], 8'h5A);
		h.xfer({8'hFF, 1'b1}, rx);
		check(rx[8:1], 8'hA5);
		h.stop;
		slave_addr = 7'h37;
		$display("read test done");
	endtask
	task automatic t_ro;
		logic a0, a1;
		slave_addr = 7'h22;
		open(8'h44);
		wr(8'h80, a0);
		wr(8'h3C, a1);
		h.stop;
		slave_addr = 7'h37;
		check({a0, a1}, 8'h03);
		check(mem[8'h80], 8'h80);
		$display("read-only test done");
	endtask
	task automatic t_wake;
		logic a;
		low_power = 1'b1;
		h.start;
		wr(8'h6E, a);
		check({a, wake_req}, 8'h01);
		h.stop;
		low_power = 1'b0;
		h.start;
		wr(8'h6E, a);
		h.stop;
		check(a, 8'h00);
		open(8'h6E);
		h.stop;
		$display("wake test done");
	endtask
	task automatic t_save;
		logic a;
		open(8'h6E);
		wr(8'h86, a);
		wr(8'h02, a);
		h.stop;
		check(save_busy, 8'h01);
		h.start;
		wr(8'h6E, a);
		h.stop;
		check(a, 8'h00);
		open(8'h6E);
		h.stop;
		$display("save test done");
	endtask
	task automatic conclude;
		$display("checks %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = i[7:0];
		repeat (20) @(negedge clock);
		sys_rst = 1'b0;
		t_boot;
		t_write;
		t_gap;
		t_read;
		t_ro;
		t_wake;
		t_save;
		conclude;
	end
	// watchdog: whole run needs well under this
	initial begin
		repeat (40000) @(posedge clock);
		n_fail++;
		conclude;
	end
endmodule // tb
bind tsi_i2c_slave tsi_i2c_slave_properties #(.BOOT_CYC(BOOT_CYC), .SAVE_CYC(SAVE_CYC), .WAKE_CYC(WAKE_CYC)) chk (
	.clock(clock), .sys_rst(sys_rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
	.low_power(low_power), .wake_req(wake_req), .bus_busy(bus_busy), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_we(reg_we), .save_busy(save_busy));
`default_nettype wire
